/* File: inc/arb_tbl_pkg.sv */
// Package of offsets, fields and constants for the VC0 arbitration table bank
package arb_tbl_pkg;
   localparam logic [11:0] status_off = 12'h118;
   localparam logic [11:0] table_word0_off = 12'h120;
   localparam logic [11:0] control_off = 12'h114;
   localparam int coherency_bit = 0;
   localparam int flow_init_bit = 1;
   localparam int load_strobe_bit = 16;
   localparam int slot_count = 9;
   localparam int slot_width = 2;
   localparam int table_bits = 18;
   localparam logic [31:0] status_reset = 32'h0000_0000;
   localparam logic [17:0] table_reset = 18'h0_0000;
   localparam logic [1:0] port_upstream = 2'h0;
   localparam logic [1:0] port_second = 2'h2;
   localparam int load_cycles = 9;
   localparam logic [3:0] load_last = 4'(load_cycles - 1);

   // APB request grouped together
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [11:0] addr;
      logic [31:0] wdata;
   } apb_req_t;

   // Load engine states
   typedef enum logic [1:0] {ld_idle, ld_copy} load_state_t;
endpackage : arb_tbl_pkg

/* File: hdl/vc0_port_arb_table_status.sv */
// VC0 port arbitration table word 0, status register and table load engine
//
// The APB interface to the registers is this design's own decision.
`timescale 1ns/10ps

module vc0_port_arb_table_status
   import arb_tbl_pkg::*;
(
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,

   // APB slave side
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,

   // Status input and arbiter side
   input wire logic flow_init_pending,
   input wire logic table_in_use,
   input wire logic arb_advance,
   output logic [1:0] arb_port,
   output logic arb_port_valid,
   output logic [3:0] arb_phase
);
   // Bus side decode
   apb_req_t req;
   logic wr_fire;
   logic rd_fire;
   logic table_wr;
   logic strobe_wr;
   logic mapped;

   // Programmed and loaded copies of the table
   logic [17:0] table_reg;
   logic [17:0] active_reg;

   // Status and read path
   logic coherency_reg;
   logic [31:0] prdata_reg;
   logic [31:0] rdata_next;

   // Load engine
   load_state_t load_state_reg;
   logic [3:0] load_cnt_reg;
   logic load_done;

   // Phase walker
   logic [3:0] phase_reg;
   logic [3:0] phase_next;
   logic [slot_count-1:0] slot_ok;

   // Bus request bundle and decode
   // Writes commit in the access phase only
   // Reads latch in setup so data stands through access
   assign req = '{sel: psel, enable: penable, write: pwrite, addr: paddr, wdata: pwdata};
   assign mapped = (req.addr == status_off) || (req.addr == table_word0_off)
                   || (req.addr == control_off);

   // Transfer qualifiers
   assign wr_fire = req.sel && req.enable && req.write && mapped;
   assign rd_fire = req.sel && !req.enable && !req.write;

   // Register selects
   assign table_wr = wr_fire && (req.addr == table_word0_off);
   assign strobe_wr = wr_fire && (req.addr == control_off)
                      && req.wdata[load_strobe_bit];
   assign load_done = (load_state_reg == ld_copy) && (load_cnt_reg == load_last);

   // Zero wait states; unmapped access flagged as error
   assign pready = 1'b1;
   assign pslverr = req.sel && req.enable && !mapped;
   assign prdata = prdata_reg;

   // Table word storage
   // Software copy only; the arbiter sees active_reg
   // Bits above the nine slots are not stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_reg <= table_reset;
      end else if (table_wr) begin
         table_reg <= req.wdata[table_bits-1:0];
      end
   end

   // Load engine copies table into arbitration logic
   // Fixed copy time; a strobe during a copy is ignored
   // Active table and phase change together at load_done
   // Counter width covers the copy time
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         load_state_reg <= ld_idle;
         load_cnt_reg <= 4'h0;
         active_reg <= table_reset;
      end else begin
         case (load_state_reg)
            // Only a written one starts a copy
            ld_idle: begin
               if (strobe_wr) begin
                  load_state_reg <= ld_copy;
                  load_cnt_reg <= 4'h0;
               end
            end
            // Count out the copy time
            ld_copy: begin
               if (load_done) begin
                  active_reg <= table_reg;
                  load_state_reg <= ld_idle;
               end else begin
                  load_cnt_reg <= load_cnt_reg + 4'h1;
               end
            end
            // Recover from an unused state code
            default: load_state_reg <= ld_idle;
         endcase
      end
   end

   // Coherency flag, set wins over clear
   // A table write in the completing cycle leaves it set
   // Cleared only by a finished copy or by reset, never by software
   // Its meaning holds only while the scheme uses the table
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         coherency_reg <= 1'b0;
      end else if (table_wr) begin
         coherency_reg <= 1'b1;
      end else if (load_done) begin
         coherency_reg <= 1'b0;
      end
   end

   // Per-slot validity of the loaded table
   // Reserved codes mark a slot to be passed over
   // Codes 0 and 2 are the only legal ports
   generate
      for (genvar i = 0; i < slot_count; i++) begin : g_slot
         assign slot_ok[i] = (active_reg[i*slot_width +: slot_width] == port_upstream)
                             || (active_reg[i*slot_width +: slot_width] == port_second);
      end
   endgenerate

   // Next valid phase, invalid slots skipped in one step
   // Smallest forward distance wins; full turn returns to self
   // With no valid slot the pointer stays put
   // Pure combinational; one step per advance
   // Walk from the farthest slot back to the nearest
   always_comb begin
      phase_next = phase_reg;
      for (int k = slot_count; k >= 1; k--) begin
         if (slot_ok[(32'(phase_reg) + k) % slot_count]) begin
            phase_next = 4'((32'(phase_reg) + k) % slot_count);
         end
      end
   end

   // Phase pointer
   // Restarts at phase 0 whenever a new table lands
   // Steps only on an advance pulse from the arbiter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         phase_reg <= 4'h0;
      end else if (load_done) begin
         phase_reg <= 4'h0;
      end else if (arb_advance) begin
         phase_reg <= phase_next;
      end
   end


   // Arbiter view of the current slot
   // Valid only while the selected scheme uses the table
   assign arb_phase = phase_reg;
   assign arb_port = active_reg[phase_reg*slot_width +: slot_width];
   assign arb_port_valid = slot_ok[phase_reg] && table_in_use;

   // Read data mux
   // Unused and reserved bits read zero
   // Control register is write-only here
   // Status bits come straight from the flag and the input
   always_comb begin
      rdata_next = 32'h0000_0000;
      case (req.addr)
         status_off: begin
            rdata_next[coherency_bit] = coherency_reg;
            rdata_next[flow_init_bit] = flow_init_pending;
         end
         table_word0_off: rdata_next[table_bits-1:0] = table_reg;
         default: rdata_next = 32'h0000_0000; // Strobe reads zero
      endcase
   end

   // Registered read data captured in setup phase
   // Held until the next read setup, so the access phase sees it
   // Writes leave it untouched
   // Unmapped reads return zero
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_reg <= status_reset;
      end else if (rd_fire) begin
         prdata_reg <= rdata_next;
      end
   end

   // Limitation: only table word 0 is held here
   // Later phases and the scheme select live elsewhere
   // Egress port identity is not checked; software keeps it out
   // Load time is a package constant, not a register field
   // Strobe bit is never stored, so it always reads zero
endmodule : vc0_port_arb_table_status

/* File: verif/vc0_tbl_checker.sv */
// Port-level assertions for the VC0 arbitration table bank
`timescale 1ns/10ps
module vc0_tbl_checker
   import arb_tbl_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pslverr,
   input wire logic flow_init_pending,
   input wire logic table_in_use,
   input wire logic [1:0] arb_port,
   input wire logic arb_port_valid,
   input wire logic [3:0] arb_phase
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Read setup cycle and mapped address
   wire rd = psel && !penable && !pwrite;
   wire hit = paddr inside {status_off, table_word0_off, control_off};
   valid_code_a: assert property (arb_port_valid == (table_in_use && !arb_port[0]))
      else $error("bad valid");
   phase_max_a: assert property (arb_phase <= 4'h8)
      else $error("bad phase");
   status_read_a: assert property (rd && paddr == status_off |=>
      prdata[31:1] == {30'h0, $past(flow_init_pending)}) else $error("bad status");
   table_read_a: assert property (rd && paddr == table_word0_off |=>
      prdata[31:18] == 14'h0) else $error("bad table");
   ctrl_read_a: assert property (rd && paddr == control_off |=> prdata == 32'h0)
      else $error("bad control");
   map_err_a: assert property (psel && penable |-> pslverr == !hit)
      else $error("bad error");
   idle_err_a: assert property (!penable |-> !pslverr)
      else $error("idle error");
   rdata_hold_a: assert property (!rd |=> $stable(prdata))
      else $error("rdata moved");
endmodule : vc0_tbl_checker
bind vc0_port_arb_table_status vc0_tbl_checker vc0_tbl_checker_i (.*);

/* File: verif/tb.sv */
// Self-checking bench for the VC0 arbitration table bank
`timescale 1ns/10ps
module tb;
   import arb_tbl_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic fip = 1'b1;
   logic adv = 1'b0;
   apb_req_t q = '0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, valid, err;
   logic use_tbl = 1'b1;
   logic [1:0] port;
   logic [3:0] phase;
   int miscompares = 0;
   int n_checks = 0;
   // Address, write data, read-back value; a legal-code row
   logic [75:0] rows [6] = '{{12'h120, 32'hFFFF_FFFF, 32'h0003_FFFF},
      {12'h120, 32'h0000_8822, 32'h0000_8822},
      {12'h120, 32'h0001_2345, 32'h0001_2345}, {12'h114, 32'hFFFE_FFFF, 32'h0},
      {12'h118, 32'hFFFF_FFFF, 32'h3}, {12'h200, 32'hFFFF_FFFF, 32'h0}};
   always #2 pclk = ~pclk;
   vc0_port_arb_table_status vc0_port_arb_table_status_i (.pclk, .presetn, .psel(q.sel),
      .penable(q.enable), .pwrite(q.write), .paddr(q.addr), .pwdata(q.wdata), .prdata,
      .pready, .pslverr, .flow_init_pending(fip), .table_in_use(use_tbl),
      .arb_advance(adv), .arb_port(port), .arb_port_valid(valid), .arb_phase(phase));
   // One APB transfer, read data left in rd
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      q <= '{1'b1, 1'b0, w, a, d};
      @(posedge pclk);
      q.enable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      q <= '0;
   endtask : apb
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      n_checks++;
      if (s !== e) begin
         miscompares++;
         $display("[ERR] %0t got %h want %h", $time, s, e);
      end
   endtask : chk
   task automatic end_of_test();
      if (miscompares == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : end_of_test
   initial begin
      #4000;
      miscompares++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      #1 chk({phase, port, valid}, {4'h0, 2'h0, 1'b1});
      foreach (rows[i]) begin
         apb(1'b1, rows[i][75:64], rows[i][63:32]);
         apb(1'b0, rows[i][75:64], 32'h0);
         chk(rd, rows[i][31:0]);
         chk(err, rows[i][75:64] == 12'h200); // unmapped read flagged
      end
      // Load with slots 1 and 2 invalid, flag held until done
      apb(1'b1, table_word0_off, 32'h0000_0036);
      apb(1'b1, control_off, 32'h0001_0000);
      apb(1'b0, status_off, 32'h0);
      chk(rd, 32'h3);
      repeat (20) if (rd[0]) apb(1'b0, status_off, 32'h0);
      chk(rd, 32'h2);
      chk({phase, port}, {4'h0, 2'h2});
      adv <= 1'b1;
      @(posedge pclk);
      adv <= 1'b0;
      #1 chk({phase, port, valid}, {4'h3, 2'h0, 1'b1});
      @(posedge pclk);
      use_tbl <= 1'b0;
      @(posedge pclk);
      #1 chk(valid, 32'h0);
      @(posedge pclk);
      use_tbl <= 1'b1;
      // Second reset in mid-run clears table and flag
      apb(1'b1, table_word0_off, 32'h0000_00FF);
      presetn <= 1'b0;
      fip <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, table_word0_off, 32'h0);
      chk(rd, 32'h0);
      apb(1'b0, status_off, 32'h0);
      chk(rd, 32'h0);
      end_of_test();
   end
endmodule : tb
